// [core/timed_output_queue_diag.sv]
// Timed output queue for four outputs with its diagnostic record.
// ************************************************************************
// Summary of operation
// - Apply queued states in order, then drop them.
// - No interrupts; diagnostics read on request only.
// - Record set one full, zero first four bytes.
// - Object 2F01h full, 2F00h first four.
// - EtherCAT fields under 5005h, own subindices.
// - Module information byte reads 1Fh.
// - Channel type 72h, bit seven zero.
// - Diagnostic bits per channel reads zero.
// - Channel count reads four.
// - Timestamp captures ticker when record generated.
// ************************************************************************
`timescale 1ns/1ps
`default_nettype none
module timed_output_queue_diag #(
	parameter int unsigned CH    = tq_pkg::CHANNELS,
	parameter int unsigned DEPTH = tq_pkg::FIFO_DEPTH
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire tq_pkg::entry_t      entry,
	input  wire logic                entry_valid,
	output logic                     entry_ready,
	input  wire logic [31:0]         ticker_us,
	input  wire tq_pkg::diag_req_t   diag_req,
	input  wire logic                diag_req_valid,
	output logic [7:0]               diag_byte,
	output logic                     diag_byte_valid,
	output logic                     diag_last,
	output logic                     diag_error,
	output logic [CH-1:0]            output_image,
	output logic [7:0]               last_applied_tag,
	output logic [7:0]               pending_entry_count,
	output logic                     interrupt_req
);

	// ********************************************************************
	// State
	// ********************************************************************
	typedef enum logic [1:0] {
		DG_IDLE = 2'b00,
		DG_SEND = 2'b01
	} diag_fsm_t;

	typedef struct packed {
		logic [31:0]   tick_meta;
		logic [31:0]   tick_sync;
		logic [CH-1:0] outputs;
		logic [7:0]    last_tag;
		logic [7:0]    pending;
		diag_fsm_t     fsm;
		logic [31:0]   stamp;
		logic [4:0]    pos;
		logic [4:0]    stop;
		logic [7:0]    byte_out;
		logic          byte_valid;
		logic          last;
		logic          err;
		logic          irq;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	tq_pkg::entry_t            head;
	logic                      head_valid;
	logic                      head_pop;
	logic [$clog2(DEPTH):0]    fifo_count;
	logic                      accept;
	logic [4:0]                start_pos;
	logic [4:0]                end_pos;

	tq_fifo #(
		.WIDTH ($bits(tq_pkg::entry_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (entry),
		.in_valid  (entry_valid),
		.in_ready  (entry_ready),
		.out_data  (head),
		.out_valid (head_valid),
		.out_ready (head_pop),
		.count     (fifo_count)
	);

	// Fire when the synchronised ticker's low half equals the stamp, so the
	// wrap from 65535 to 0 needs no special handling.
	assign head_pop = head_valid &&
		(s_q.tick_sync[tq_pkg::TIME_W-1:0] == head.time_us);

	// Byte of the record at a given offset; reserved bytes give zero.
	function automatic logic [7:0] record_byte(input logic [4:0] ofs,
		input logic [31:0] ts);
		logic [7:0] b;
		b = tq_pkg::RESERVED_BYTE;
		case (ofs)
			tq_pkg::OFS_MODTYPE: b = tq_pkg::MODULE_INFO;
			tq_pkg::OFS_CHTYPE:  b = {1'b0, tq_pkg::CHTYPE_CODE};
			tq_pkg::OFS_BITS:    b = tq_pkg::DIAG_BITS;
			tq_pkg::OFS_CHCOUNT: b = tq_pkg::CHANNEL_NUM;
			default: begin
				if (ofs >= tq_pkg::OFS_STAMP) begin
					b = ts[8*(ofs - tq_pkg::OFS_STAMP) +: 8];
				end
			end
		endcase
		return b;
	endfunction : record_byte

	// ********************************************************************
	// Request decode
	// ********************************************************************
	always_comb begin
		accept    = 1'b1;
		start_pos = tq_pkg::OFS_ERR_A;
		end_pos   = 5'(tq_pkg::RECORD_BYTES - 1);
		case (diag_req.path)
			tq_pkg::PATH_SET: begin
				if (diag_req.sel == tq_pkg::SET_SHORT) begin
					end_pos = 5'(tq_pkg::SHORT_BYTES - 1);
				end else if (diag_req.sel != tq_pkg::SET_FULL) begin
					accept = 1'b0;
				end
			end
			tq_pkg::PATH_CAN: begin
				if (diag_req.index == tq_pkg::OBJ_SHORT) begin
					end_pos = 5'(tq_pkg::SHORT_BYTES - 1);
				end else if (diag_req.index != tq_pkg::OBJ_FULL) begin
					accept = 1'b0;
				end
			end
			tq_pkg::PATH_ECAT: begin
				// One field per subindex; the stamp field is four bytes.
				if (diag_req.index != tq_pkg::ECAT_INDEX) begin
					accept = 1'b0;
				end else if (diag_req.sel == tq_pkg::SUB_STAMP) begin
					start_pos = tq_pkg::OFS_STAMP;
					end_pos   = 5'(tq_pkg::RECORD_BYTES - 1);
				end else if (diag_req.sel >= tq_pkg::SUB_FIRST &&
					diag_req.sel <= tq_pkg::SUB_LAST_ERR) begin
					start_pos = 5'(diag_req.sel - tq_pkg::SUB_FIRST);
					end_pos   = start_pos;
				end else begin
					accept = 1'b0;
				end
			end
			default: accept = 1'b0;
		endcase
	end

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		s_d            = s_q;
		s_d.tick_meta  = ticker_us;
		s_d.tick_sync  = s_q.tick_meta;
		s_d.byte_valid = 1'b0;
		s_d.last       = 1'b0;
		s_d.err        = 1'b0;
		s_d.irq        = 1'b0;
		s_d.pending    = 8'(fifo_count);
		if (head_pop) begin
			s_d.outputs  = head.state;
			s_d.last_tag = head.tag;
		end
		case (s_q.fsm)
			DG_IDLE: begin
				if (diag_req_valid) begin
					if (accept) begin
						s_d.stamp = s_q.tick_sync;
						s_d.pos   = start_pos;
						s_d.stop  = end_pos;
						s_d.fsm   = DG_SEND;
					end else begin
						s_d.err = 1'b1;
					end
				end
			end
			DG_SEND: begin
				s_d.byte_out   = record_byte(s_q.pos, s_q.stamp);
				s_d.byte_valid = 1'b1;
				s_d.pos        = s_q.pos + 5'h01;
				if (s_q.pos == s_q.stop) begin
					s_d.last = 1'b1;
					s_d.fsm  = DG_IDLE;
				end
			end
			default: s_d.fsm = DG_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign output_image        = s_q.outputs;
	assign last_applied_tag    = s_q.last_tag;
	assign pending_entry_count = s_q.pending;
	assign diag_byte           = s_q.byte_out;
	assign diag_byte_valid     = s_q.byte_valid;
	assign diag_last           = s_q.last;
	assign diag_error          = s_q.err;
	// The module never interrupts; diagnostics are polled.
	assign interrupt_req       = s_q.irq;

endmodule : timed_output_queue_diag
`default_nettype wire

// [core/tq_pkg.sv]
// Package with constants, types and record layout for the timed output queue.
package tq_pkg;

	// ********************************************************************
	// Sizes and record values
	// ********************************************************************
	localparam int unsigned CHANNELS       = 4;
	localparam int unsigned TAG_W          = 8;
	localparam int unsigned TIME_W         = 16;
	localparam int unsigned FIFO_DEPTH     = 4;
	localparam int unsigned RECORD_BYTES   = 20;
	localparam int unsigned SHORT_BYTES    = 4;
	localparam logic [7:0]  MODULE_INFO    = 8'h1F;
	localparam logic [7:0]  CHANNEL_TYPE   = 8'h72;
	localparam logic [7:0]  DIAG_BITS      = 8'h00;
	localparam logic [7:0]  CHANNEL_NUM    = 8'h04;
	localparam logic [7:0]  RESERVED_BYTE  = 8'h00;
	localparam logic [6:0]  CHTYPE_CODE    = 7'h72;
	localparam int unsigned LAST_TAG_BIT   = 6;

	// ********************************************************************
	// Access paths to the record
	// ********************************************************************
	localparam logic [7:0]  SET_FULL       = 8'h01;
	localparam logic [7:0]  SET_SHORT      = 8'h00;
	localparam logic [15:0] OBJ_FULL       = 16'h2F01;
	localparam logic [15:0] OBJ_SHORT      = 16'h2F00;
	localparam logic [15:0] ECAT_INDEX     = 16'h5005;

	// Byte offsets of record fields.
	localparam logic [4:0]  OFS_ERR_A      = 5'h00;
	localparam logic [4:0]  OFS_MODTYPE    = 5'h01;
	localparam logic [4:0]  OFS_CHTYPE     = 5'h04;
	localparam logic [4:0]  OFS_BITS       = 5'h05;
	localparam logic [4:0]  OFS_CHCOUNT    = 5'h06;
	localparam logic [4:0]  OFS_STAMP      = 5'h10;

	// Subindex of each field on the EtherCAT path.
	localparam logic [7:0]  SUB_FIRST      = 8'h02;
	localparam logic [7:0]  SUB_LAST_ERR   = 8'h11;
	localparam logic [7:0]  SUB_STAMP      = 8'h13;

	typedef enum logic [1:0] {
		PATH_SET  = 2'b00,
		PATH_CAN  = 2'b01,
		PATH_ECAT = 2'b10
	} diag_path_t;

	typedef struct packed {
		logic [CHANNELS-1:0] state;
		logic [TAG_W-1:0]    tag;
		logic [TIME_W-1:0]   time_us;
	} entry_t;

	typedef struct packed {
		diag_path_t  path;
		logic [15:0] index;
		logic [7:0]  sel;
	} diag_req_t;

endpackage : tq_pkg

// [core/tq_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module tq_fifo #(
	parameter int unsigned WIDTH = 28,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [$clog2(DEPTH):0] count
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
		logic                        not_full;
	} fifo_state_t;

	fifo_state_t s_q;
	fifo_state_t s_d;
	logic        push;
	logic        pop;

	always_comb begin
		s_d  = s_q;
		push = in_valid && (s_q.cnt != DEPTH[AW:0]);
		pop  = out_ready && (s_q.cnt != '0);
		if (push) begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
		end
		s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		// Ready has its own flop so the port comes straight from a register.
		s_d.not_full = (s_d.cnt != DEPTH[AW:0]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{mem: '0, wr: '0, rd: '0, cnt: '0, not_full: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign in_ready  = s_q.not_full;
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rd];
	assign count     = s_q.cnt;
endmodule : tq_fifo
`default_nettype wire

// [tb/tq_monitor.sv]
// Port checker for the timed output queue.
`timescale 1ns/1ps
`default_nettype none
module tq_monitor #(
	parameter int unsigned CH    = 4,
	parameter int unsigned DEPTH = 4
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire tq_pkg::entry_t    entry,
	input wire logic              entry_valid,
	input wire logic              entry_ready,
	input wire logic [31:0]       ticker_us,
	input wire tq_pkg::diag_req_t diag_req,
	input wire logic              diag_req_valid,
	input wire logic [7:0]        diag_byte,
	input wire logic              diag_byte_valid,
	input wire logic              diag_last,
	input wire logic              diag_error,
	input wire logic [CH-1:0]     output_image,
	input wire logic [7:0]        last_applied_tag,
	input wire logic [7:0]        pending_entry_count,
	input wire logic              interrupt_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Valid, path, index and subindex in one word keep antecedents short.
	wire logic [26:0] rq = {diag_req_valid, diag_req};
	sequence full_s;
		##2 diag_byte == 8'h00 ##1 diag_byte == 8'h1F ##18 diag_last;
	endsequence
	irq_quiet_a: assert property (!interrupt_req)
		else $error("interrupt raised");
	set_full_a: assert property (rq == 27'h4000001 |-> full_s)
		else $error("set one record wrong");
	set_short_a: assert property (rq == 27'h4000000 |->
		##2 (diag_byte_valid && !diag_last)[*3] ##1 diag_last)
		else $error("set zero length wrong");
	can_full_a: assert property (rq == 27'h52F0100 |-> full_s)
		else $error("full object wrong");
	can_short_a: assert property (rq == 27'h52F0000 |->
		##5 diag_last && diag_byte_valid)
		else $error("short object wrong");
	ecat_type_a: assert property (rq == 27'h6500506 |->
		##2 diag_last && diag_byte == 8'h72)
		else $error("channel type wrong");
	bad_sub_a: assert property (rq == 27'h6500512 |-> ##1 diag_error)
		else $error("bad subindex accepted");
	bad_path_a: assert property (rq == 27'h7000000 |-> ##1 diag_error)
		else $error("unknown path accepted");
	bad_set_a: assert property (rq == 27'h4000002 |-> ##1 diag_error)
		else $error("unknown record set accepted");
	fill_bound_a: assert property (pending_entry_count <= DEPTH)
		else $error("pending count too high");
endmodule : tq_monitor
bind timed_output_queue_diag tq_monitor #(.CH(CH), .DEPTH(DEPTH)) u_mon (
	.clk, .rst_n, .entry, .entry_valid, .entry_ready, .ticker_us,
	.diag_req, .diag_req_valid, .diag_byte, .diag_byte_valid, .diag_last,
	.diag_error, .output_image, .last_applied_tag, .pending_entry_count,
	.interrupt_req);
`default_nettype wire

// [tb/tq_head_ticker.sv]
// Head module model that supplies the microsecond ticker.
`timescale 1ns/1ps
`default_nettype none
module tq_head_ticker (
	input  wire logic        clk,
	input  wire logic        run,
	input  wire logic        load,
	input  wire logic [31:0] load_val,
	output logic      [31:0] ticker_us = 32'h0
);
	// Steps once a clock, not once a microsecond, to keep wraps short.
	always @(posedge clk) begin
		if (load) begin
			ticker_us <= load_val;
		end else if (run) begin
			ticker_us <= ticker_us + 32'h1;
		end
	end
endmodule : tq_head_ticker
`default_nettype wire

// [tb/tb_timed_output_queue_diag.sv]
// Self-checking bench for the timed output queue.
`timescale 1ns/1ps
`default_nettype none
module tb_timed_output_queue_diag;
	logic clk = 1'b0, rst_n = 1'b0, ev = 1'b0, rv = 1'b0, run = 1'b0;
	logic ld = 1'b1, er, dv, dl, de, irq;
	logic [31:0] lv = 32'h0000FFF0, tick;
	logic [7:0] db, tag, cnt, rec [24];
	logic [3:0] img, st [5] = '{4'hF, 4'hB, 4'h3, 4'hB, 4'h0};
	logic [7:0] tg [5] = '{8'h06, 8'h07, 8'h08, 8'h49, 8'h4A};
	logic [15:0] dt, ts [5] = '{16'hFFF8, 16'h0008, 16'h0018, 16'h0028,
		16'h0038};
	tq_pkg::entry_t ent = '0;
	tq_pkg::diag_req_t rq = '0;
	int miscompares = 0, comparisons = 0;
	always #20 clk = ~clk;
	tq_head_ticker i_tq_head_ticker (.clk, .run, .load(ld), .load_val(lv),
		.ticker_us(tick));
	timed_output_queue_diag i_timed_output_queue_diag (.clk, .rst_n,
		.entry(ent), .entry_valid(ev), .entry_ready(er), .ticker_us(tick),
		.diag_req(rq), .diag_req_valid(rv), .diag_byte(db),
		.diag_byte_valid(dv), .diag_last(dl), .diag_error(de),
		.output_image(img), .last_applied_tag(tag),
		.pending_entry_count(cnt), .interrupt_req(irq));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task close_out(input int hung);
		miscompares += hung;
		$display("%0d compares, %0d mismatches", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out
	task put(input int i);
		ent <= '{st[i], tg[i], ts[i]};
		ev <= 1'b1;
		for (int k = 0; k < 200 && !er; k++) begin
			@(negedge clk);
		end
		if (!er) close_out(1);
		@(negedge clk);
	endtask : put
	// Path code sits above index and subindex in the request word.
	task diag(input logic [25:0] r, input int ofs, input int n);
		int k;
		k = 0;
		@(negedge clk);
		rq <= r;
		rv <= 1'b1;
		for (int c = 0; c < 30 && !(dl | de); c++) begin
			@(negedge clk);
			rv <= 1'b0;
			if (dv) begin
				check(db, rec[ofs + k]);
				k++;
			end
		end
		if (!(dl | de)) close_out(1);
		check(k, n);
		check(de, n == 0);
	endtask : diag
	initial begin
		for (int i = 0; i < 24; i++) begin
			rec[i] = 8'h00;
		end
		rec[1] = 8'h1F;
		rec[4] = 8'h72;
		rec[6] = 8'h04;
		repeat (8) @(negedge clk);
		check(er, 1'b1);
		check(img, 4'h0);
		rst_n <= 1'b1;
		ld <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			put(i);
		end
		ev <= 1'b0;
		@(negedge clk);
		check(er, 1'b0);
		check(cnt, 8'h04);
		run <= 1'b1;
		fork
			begin
				put(4);
				ev <= 1'b0;
			end
		join_none
		for (int i = 0; i < 5; i++) begin
			for (int k = 0; k < 100 && tag !== tg[i]; k++) begin
				@(negedge clk);
			end
			if (tag !== tg[i]) close_out(1);
			dt = tick[15:0] - ts[i];
			check(img, st[i]);
			check(dt > 16'h0 && dt < 16'h7, 1'b1);
		end
		repeat (3) @(negedge clk);
		check(cnt, 8'h00);
		$display("entry queue test done");
		ld <= 1'b1;
		lv <= 32'hA5C30F96;
		run <= 1'b0;
		{rec[19], rec[18], rec[17], rec[16]} = 32'hA5C30F96;
		repeat (4) @(negedge clk);
		ld <= 1'b0;
		diag(26'h0000001, 0, 20);
		diag(26'h0000000, 0, 4);
		diag(26'h12F0100, 0, 20);
		diag(26'h12F0000, 0, 4);
		for (int s = 2; s < 18; s++) begin
			diag(26'h2500500 + 26'(s), s - 2, 1);
		end
		diag(26'h2500513, 16, 4);
		diag(26'h2500512, 0, 0);
		diag(26'h2400502, 0, 0);
		diag(26'h3000000, 0, 0);
		diag(26'h0000002, 0, 0);
		diag(26'h12F0200, 0, 0);
		check(irq, 1'b0);
		$display("record read test done");
		close_out(0);
	end
endmodule : tb_timed_output_queue_diag
`default_nettype wire
